/* File: src/dma_addr_gen.sv */
// Four-channel DMA address generator: pointers, counts, frame sync, lanes.
// Assumes an outside arbiter that pulses read_done/write_done per transfer.
//
// Notes on behaviour
// - Each channel keeps read and write pointers, updated after each transfer.
// - Step select 00b leaves that pointer unchanged.
// - Increment or decrement moves the pointer by the element size.
// - Step select 11b uses steps from a shared step register.
// - Channel control picks which shared step register applies.
// - Shared step register: signed element step low, signed frame step high.
// - Element step is added after every transfer but a frame's last.
// - Frame step is added after each frame's last transfer, including the final.
// - Element width selects byte, halfword or word.
// - Byte lanes follow little- or big-endian addressing.
// - First frame uses initial element count, later frames the reload count.
// - Each channel computes read and write addresses independently.
// - With frame sync enabled, the selected event opens a whole frame.
`timescale 1ns/100ps
`default_nettype none
module dma_addr_gen #(
  parameter int NCH = dma_addr_pkg::NCH,
  parameter int NEVT = dma_addr_pkg::NEVT
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [dma_addr_pkg::AW-1:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata,
  input wire logic [NCH-1:0] read_done,
  input wire logic [NCH-1:0] write_done,
  input wire logic [NEVT:1] sync_event,
  output logic [NCH-1:0][31:0] read_addr,
  output logic [NCH-1:0][31:0] write_addr,
  output logic [NCH-1:0][3:0] read_lanes,
  output logic [NCH-1:0][3:0] write_lanes,
  output logic [NCH-1:0] read_last,
  output logic [NCH-1:0] write_last,
  output logic [NCH-1:0] read_permit,
  output logic [NCH-1:0] channel_active
);

  // ----------------------------------------
  // Shared registers
  // ----------------------------------------
  dma_addr_pkg::step_t step0_r;
  dma_addr_pkg::step_t step1_r;
  logic big_endian_r;
  logic [31:0] rdata_r;
  logic [NCH-1:0][31:0] ch_rdata;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      step0_r <= dma_addr_pkg::STEP_RESET;
      step1_r <= dma_addr_pkg::STEP_RESET;
      big_endian_r <= 1'b0;
    end else if (reg_wr) begin
      if (reg_addr == dma_addr_pkg::OFS_STEP0) step0_r <= reg_wdata;
      if (reg_addr == dma_addr_pkg::OFS_STEP1) step1_r <= reg_wdata;
      if (reg_addr == dma_addr_pkg::OFS_CFG) big_endian_r <= reg_wdata[dma_addr_pkg::CFG_BIG_ENDIAN_BIT];
    end
  end

  // ----------------------------------------
  // Event input synchroniser
  // ----------------------------------------
  // Three stages; a change counts once stages two and three agree
  logic [NEVT:1] sync_a_r;
  logic [NEVT:1] sync_b_r;
  logic [NEVT:1] sync_c_r;
  logic [NEVT:1] stable_r;
  logic [NEVT:0] evt_rise;

  always_ff @(posedge clk) begin
    if (!rst_n) begin
      sync_a_r <= '0;
      sync_b_r <= '0;
      sync_c_r <= '0;
      stable_r <= '0;
    end else begin
      sync_a_r <= sync_event;
      sync_b_r <= sync_a_r;
      sync_c_r <= sync_b_r;
      stable_r <= (sync_b_r & sync_c_r) | (stable_r & (sync_b_r | sync_c_r));
    end
  end

  // Selector value zero means no event, so bit zero never fires
  assign evt_rise = {(sync_b_r & sync_c_r & ~stable_r), 1'b0};

  // ----------------------------------------
  // Per-channel logic
  // ----------------------------------------
  genvar c;
  generate
    for (c = 0; c < NCH; c++) begin : g_ch
      localparam logic [7:0] BASE = 8'(c * dma_addr_pkg::CH_STRIDE);
      dma_addr_pkg::ctrl_t ctrl_r;
      dma_addr_pkg::chan_state_t st_r;
      dma_addr_pkg::step_t sel_step;
      logic [31:0] src_r;
      logic [31:0] dst_r;
      logic [31:0] src_upd;
      logic [31:0] dst_upd;
      logic [31:0] src_nxt;
      logic [31:0] dst_nxt;
      logic [31:0] cnt_r;
      logic [15:0] reload_r;
      logic [15:0] rd_ecnt_r;
      logic [15:0] rd_fcnt_r;
      logic [15:0] wr_ecnt_r;
      logic [15:0] wr_fcnt_r;
      logic [15:0] rd_ecnt_nxt;
      logic [15:0] wr_ecnt_nxt;
      logic [3:0] rd_lanes_c;
      logic [3:0] wr_lanes_c;
      logic [3:0] rd_lanes_r;
      logic [3:0] wr_lanes_r;
      logic rd_last_r;
      logic wr_last_r;
      logic permit_r;
      logic evt_flag_r;
      logic frame_open_r;
      logic wr_ctrl;
      logic wr_src;
      logic wr_dst;
      logic start_go;
      logic rd_last;
      logic wr_last;
      logic rd_fire;
      logic wr_fire;
      logic evt_seen;
      logic evt_take;

      assign wr_ctrl = reg_wr && (reg_addr == BASE + dma_addr_pkg::OFS_CTRL);
      assign wr_src = reg_wr && (reg_addr == BASE + dma_addr_pkg::OFS_SRC);
      assign wr_dst = reg_wr && (reg_addr == BASE + dma_addr_pkg::OFS_DST);
      assign start_go = wr_ctrl && reg_wdata[13] && (st_r == dma_addr_pkg::CH_IDLE);
      assign sel_step = ctrl_r.index_select ? step1_r : step0_r;
      assign rd_last = (rd_ecnt_r == dma_addr_pkg::COUNT_ONE);
      assign wr_last = (wr_ecnt_r == dma_addr_pkg::COUNT_ONE);
      // Transfers reported outside an active block are ignored
      assign rd_fire = read_done[c] && (st_r == dma_addr_pkg::CH_ACTIVE) && (rd_fcnt_r != '0);
      assign wr_fire = write_done[c] && (st_r == dma_addr_pkg::CH_ACTIVE) && (wr_fcnt_r != '0);
      assign evt_seen = evt_rise[ctrl_r.read_event_select];
      // Frame mode consumes the event at the first read of a frame only
      assign evt_take = rd_fire && !(ctrl_r.frame_sync_enable && frame_open_r);

      ptr_step u_src_step (
        .ptr(src_r),
        .sel(ctrl_r.read_step_select),
        .width(ctrl_r.element_width),
        .step(sel_step),
        .last(rd_last),
        .nxt(src_upd)
      );

      ptr_step u_dst_step (
        .ptr(dst_r),
        .sel(ctrl_r.write_step_select),
        .width(ctrl_r.element_width),
        .step(sel_step),
        .last(wr_last),
        .nxt(dst_upd)
      );

      // A software write to a pointer wins over a same-cycle update
      assign src_nxt = wr_src ? reg_wdata : (rd_fire ? src_upd : src_r);
      assign dst_nxt = wr_dst ? reg_wdata : (wr_fire ? dst_upd : dst_r);
      assign rd_ecnt_nxt = start_go ? cnt_r[15:0]
                         : (rd_fire ? (rd_last ? reload_r : rd_ecnt_r - 16'h0001) : rd_ecnt_r);
      assign wr_ecnt_nxt = start_go ? cnt_r[15:0]
                         : (wr_fire ? (wr_last ? reload_r : wr_ecnt_r - 16'h0001) : wr_ecnt_r);

      lane_sel u_rd_lanes (
        .addr(src_nxt[1:0]),
        .width(ctrl_r.element_width),
        .big_endian(big_endian_r),
        .lanes(rd_lanes_c)
      );

      lane_sel u_wr_lanes (
        .addr(dst_nxt[1:0]),
        .width(ctrl_r.element_width),
        .big_endian(big_endian_r),
        .lanes(wr_lanes_c)
      );

      // ----------------------------------------
      // Configuration
      // ----------------------------------------
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          ctrl_r <= dma_addr_pkg::CTRL_RESET;
          cnt_r <= '0;
          reload_r <= '0;
        end else begin
          // Control is frozen while a block runs so steps stay consistent
          if (wr_ctrl && st_r == dma_addr_pkg::CH_IDLE) ctrl_r <= reg_wdata;
          if (reg_wr && reg_addr == BASE + dma_addr_pkg::OFS_CNT) cnt_r <= reg_wdata;
          if (reg_wr && reg_addr == BASE + dma_addr_pkg::OFS_RELOAD) reload_r <= reg_wdata[15:0];
        end
      end

      // ----------------------------------------
      // Pointers and lanes
      // ----------------------------------------
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          src_r <= '0;
          dst_r <= '0;
          rd_lanes_r <= '0;
          wr_lanes_r <= '0;
        end else begin
          src_r <= src_nxt;
          dst_r <= dst_nxt;
          rd_lanes_r <= rd_lanes_c;
          wr_lanes_r <= wr_lanes_c;
        end
      end

      // ----------------------------------------
      // Element and frame counts
      // ----------------------------------------
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          st_r <= dma_addr_pkg::CH_IDLE;
          rd_ecnt_r <= '0;
          rd_fcnt_r <= '0;
          wr_ecnt_r <= '0;
          wr_fcnt_r <= '0;
          rd_last_r <= 1'b0;
          wr_last_r <= 1'b0;
        end else begin
          rd_ecnt_r <= rd_ecnt_nxt;
          wr_ecnt_r <= wr_ecnt_nxt;
          rd_last_r <= (rd_ecnt_nxt == dma_addr_pkg::COUNT_ONE);
          wr_last_r <= (wr_ecnt_nxt == dma_addr_pkg::COUNT_ONE);
          if (start_go) begin
            rd_fcnt_r <= cnt_r[31:dma_addr_pkg::CNT_FRAME_LSB];
            wr_fcnt_r <= cnt_r[31:dma_addr_pkg::CNT_FRAME_LSB];
          end else begin
            if (rd_fire && rd_last) rd_fcnt_r <= rd_fcnt_r - 16'h0001;
            if (wr_fire && wr_last) wr_fcnt_r <= wr_fcnt_r - 16'h0001;
          end
          case (st_r)
            dma_addr_pkg::CH_IDLE: begin
              if (start_go) st_r <= dma_addr_pkg::CH_ACTIVE;
            end
            dma_addr_pkg::CH_ACTIVE: begin
              // Block ends once the last write of the last frame is done
              if (wr_fcnt_r == '0 || (wr_fire && wr_last && wr_fcnt_r == dma_addr_pkg::COUNT_ONE)) begin
                st_r <= dma_addr_pkg::CH_IDLE;
              end
            end
            default: st_r <= dma_addr_pkg::CH_IDLE;
          endcase
        end
      end

      // ----------------------------------------
      // Read synchronisation
      // ----------------------------------------
      always_ff @(posedge clk) begin
        if (!rst_n) begin
          evt_flag_r <= 1'b0;
          frame_open_r <= 1'b0;
          permit_r <= 1'b0;
        end else begin
          // A new event in the consuming cycle is kept: set wins
          if (evt_seen) evt_flag_r <= 1'b1;
          else if (evt_take || start_go) evt_flag_r <= 1'b0;
          if (start_go) frame_open_r <= 1'b0;
          else if (rd_fire && ctrl_r.frame_sync_enable) frame_open_r <= !rd_last;
          // Permit lags a read by one cycle; reads come at most every other cycle
          permit_r <= (st_r == dma_addr_pkg::CH_ACTIVE) && !start_go && !rd_fire
                      && (rd_fcnt_r != '0)
                      && ((ctrl_r.read_event_select == '0) || evt_flag_r
                          || (ctrl_r.frame_sync_enable && frame_open_r));
        end
      end

      // ----------------------------------------
      // Outputs and readback
      // ----------------------------------------
      assign read_addr[c] = src_r;
      assign write_addr[c] = dst_r;
      assign read_lanes[c] = rd_lanes_r;
      assign write_lanes[c] = wr_lanes_r;
      assign read_last[c] = rd_last_r;
      assign write_last[c] = wr_last_r;
      assign read_permit[c] = permit_r;
      assign channel_active[c] = (st_r == dma_addr_pkg::CH_ACTIVE);

      always_comb begin
        case (reg_addr)
          BASE + dma_addr_pkg::OFS_CTRL: begin
            ch_rdata[c] = {ctrl_r.rsvd, (st_r == dma_addr_pkg::CH_ACTIVE), ctrl_r[12:0]};
          end
          BASE + dma_addr_pkg::OFS_SRC: ch_rdata[c] = src_r;
          BASE + dma_addr_pkg::OFS_DST: ch_rdata[c] = dst_r;
          BASE + dma_addr_pkg::OFS_CNT: ch_rdata[c] = {rd_fcnt_r, rd_ecnt_r};
          BASE + dma_addr_pkg::OFS_RELOAD: ch_rdata[c] = {16'h0000, reload_r};
          default: ch_rdata[c] = '0;
        endcase
      end
    end
  endgenerate

  // ----------------------------------------
  // Read data, one cycle after the strobe
  // ----------------------------------------
  logic [31:0] rd_mux;
  always_comb begin
    rd_mux = '0;
    for (int i = 0; i < NCH; i++) rd_mux = rd_mux | ch_rdata[i];
    case (reg_addr)
      dma_addr_pkg::OFS_STEP0: rd_mux = step0_r;
      dma_addr_pkg::OFS_STEP1: rd_mux = step1_r;
      dma_addr_pkg::OFS_CFG: rd_mux = {31'h0000_0000, big_endian_r};
      default: rd_mux = rd_mux;
    endcase
  end

  always_ff @(posedge clk) begin
    if (!rst_n) rdata_r <= '0;
    else if (reg_rd) rdata_r <= rd_mux;
    else rdata_r <= '0;
  end
  assign reg_rdata = rdata_r;

endmodule : dma_addr_gen
`default_nettype wire

/* File: src/dma_addr_pkg.sv */
// Shared constants and types for the DMA channel address generator.
// Assumes one clock domain and a simple strobe register port.
package dma_addr_pkg;

  // ----------------------------------------
  // Sizes
  // ----------------------------------------
  localparam int NCH = 4;
  localparam int NEVT = 31;
  localparam int AW = 8;

  // ----------------------------------------
  // Register map
  // ----------------------------------------
  localparam logic [7:0] CH_STRIDE = 8'h20;
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_SRC = 8'h04;
  localparam logic [7:0] OFS_DST = 8'h08;
  localparam logic [7:0] OFS_CNT = 8'h0c;
  localparam logic [7:0] OFS_RELOAD = 8'h10;
  localparam logic [7:0] OFS_STEP0 = 8'h80;
  localparam logic [7:0] OFS_STEP1 = 8'h84;
  localparam logic [7:0] OFS_CFG = 8'h88;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] STEP_RESET = 32'h0000_0000;
  localparam int CFG_BIG_ENDIAN_BIT = 0;
  localparam int CNT_FRAME_LSB = 16;

  // ----------------------------------------
  // Element sizes and lane patterns
  // ----------------------------------------
  localparam logic [31:0] SIZE_BYTE = 32'h0000_0001;
  localparam logic [31:0] SIZE_HALF = 32'h0000_0002;
  localparam logic [31:0] SIZE_WORD = 32'h0000_0004;
  localparam logic [3:0] LANE_LOW_BYTE = 4'h1;
  localparam logic [3:0] LANE_HIGH_BYTE = 4'h8;
  localparam logic [3:0] LANE_LOW_HALF = 4'h3;
  localparam logic [3:0] LANE_HIGH_HALF = 4'hc;
  localparam logic [3:0] LANE_ALL = 4'hf;
  localparam logic [15:0] COUNT_ONE = 16'h0001;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef enum logic [1:0] {STEP_HOLD, STEP_INC, STEP_DEC, STEP_INDEX} step_sel_t;
  typedef enum logic [1:0] {WID_BYTE, WID_HALF, WID_WORD, WID_RSVD} width_t;
  typedef enum logic {CH_IDLE, CH_ACTIVE} chan_state_t;

  typedef struct packed {
    logic [17:0] rsvd;
    logic start_busy;
    logic [4:0] read_event_select;
    logic frame_sync_enable;
    logic index_select;
    width_t element_width;
    step_sel_t write_step_select;
    step_sel_t read_step_select;
  } ctrl_t;

  typedef struct packed {
    logic signed [15:0] frame_step;
    logic signed [15:0] element_step;
  } step_t;

endpackage : dma_addr_pkg

/* File: src/ptr_step.sv */
// Next-pointer arithmetic for one pointer after one transfer.
// Pure combinational; the caller decides when to load the result.
`timescale 1ns/100ps
`default_nettype none
module ptr_step (
  input wire logic [31:0] ptr,
  input wire dma_addr_pkg::step_sel_t sel,
  input wire dma_addr_pkg::width_t width,
  input wire dma_addr_pkg::step_t step,
  input wire logic last,
  output logic [31:0] nxt
);
  logic [31:0] size;
  logic [31:0] idx;

  always_comb begin
    case (width)
      dma_addr_pkg::WID_BYTE: size = dma_addr_pkg::SIZE_BYTE;
      dma_addr_pkg::WID_HALF: size = dma_addr_pkg::SIZE_HALF;
      default: size = dma_addr_pkg::SIZE_WORD;
    endcase
    // Sign extension keeps negative steps wrapping correctly
    idx = last ? {{16{step.frame_step[15]}}, step.frame_step}
               : {{16{step.element_step[15]}}, step.element_step};
    case (sel)
      dma_addr_pkg::STEP_HOLD: nxt = ptr;
      dma_addr_pkg::STEP_INC: nxt = ptr + size;
      dma_addr_pkg::STEP_DEC: nxt = ptr - size;
      dma_addr_pkg::STEP_INDEX: nxt = ptr + idx;
      default: nxt = ptr;
    endcase
  end
endmodule : ptr_step
`default_nettype wire

/* File: src/lane_sel.sv */
// Byte lanes of a 32-bit location touched by one element.
// Misaligned halfwords are undefined; only address bit 1 is used then.
`timescale 1ns/100ps
`default_nettype none
module lane_sel (
  input wire logic [1:0] addr,
  input wire dma_addr_pkg::width_t width,
  input wire logic big_endian,
  output logic [3:0] lanes
);
  always_comb begin
    case (width)
      dma_addr_pkg::WID_BYTE: lanes = big_endian ? 4'(dma_addr_pkg::LANE_HIGH_BYTE >> addr)
                                                 : 4'(dma_addr_pkg::LANE_LOW_BYTE << addr);
      dma_addr_pkg::WID_HALF: lanes = (addr[1] ^ big_endian) ? dma_addr_pkg::LANE_HIGH_HALF
                                                            : dma_addr_pkg::LANE_LOW_HALF;
      default: lanes = dma_addr_pkg::LANE_ALL;
    endcase
  end
endmodule : lane_sel
`default_nettype wire

/* File: tb/dma_addr_gen_chk.sv */
// Port-level assertions for the DMA address generator, channels 0 and 1.
// Assumes binding onto dma_addr_gen; sees its ports only.
`timescale 1ns/100ps
`default_nettype none
module dma_addr_gen_chk #(
  parameter int NCH = 4,
  parameter int NEVT = 31
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic [NCH-1:0] read_done,
  input wire logic [NCH-1:0] write_done,
  input wire logic [NEVT:1] sync_event,
  input wire logic [NCH-1:0][31:0] read_addr,
  input wire logic [NCH-1:0][31:0] write_addr,
  input wire logic [NCH-1:0][3:0] read_lanes,
  input wire logic [NCH-1:0][3:0] write_lanes,
  input wire logic [NCH-1:0] read_last,
  input wire logic [NCH-1:0] write_last,
  input wire logic [NCH-1:0] read_permit,
  input wire logic [NCH-1:0] channel_active
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  property p_ptr_still;
    !read_done[0] && !reg_wr |=> $stable(read_addr[0]);
  endproperty
  a_ptr_still: assert property (p_ptr_still) else $error("read pointer moved without cause");
  property p_idle_done;
    read_done[0] && !channel_active[0] && !reg_wr |=> $stable(read_addr[0]);
  endproperty
  a_idle_done: assert property (p_idle_done) else $error("idle channel moved pointer");
  property p_wr_indep;
    read_done[0] && !write_done[0] && !reg_wr |=> $stable(write_addr[0]);
  endproperty
  a_wr_indep: assert property (p_wr_indep) else $error("read moved write pointer");
  property p_ch_indep;
    read_done[0] && !read_done[1] && !reg_wr |=> $stable(read_addr[1]);
  endproperty
  a_ch_indep: assert property (p_ch_indep) else $error("channel 0 moved channel 1");
  property p_permit_drop;
    read_done[0] && channel_active[0] |=> !read_permit[0];
  endproperty
  a_permit_drop: assert property (p_permit_drop) else $error("permit held after read");
  property p_permit_active;
    read_permit[1] |-> channel_active[1];
  endproperty
  a_permit_active: assert property (p_permit_active) else $error("permit while idle");
  property p_lanes_ok;
    channel_active[0] |-> read_lanes[0] inside {4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'hc, 4'hf};
  endproperty
  a_lanes_ok: assert property (p_lanes_ok) else $error("bad lane pattern");
  property p_rdata_idle;
    !reg_rd |=> reg_rdata == 32'h0000_0000;
  endproperty
  a_rdata_idle: assert property (p_rdata_idle) else $error("read data outside its slot");
endmodule : dma_addr_gen_chk
`default_nettype wire

/* File: tb/tb.sv */
// Self-checking bench for dma_addr_gen over its register port and done pulses.
// Assumes the package offsets and the hand-over timing of the design.
`timescale 1ns/100ps
`default_nettype none
module tb;
  localparam int NCH = 4;
  localparam int NEVT = 31;
  logic clk, rst_n, reg_wr, reg_rd;
  logic [7:0] reg_addr;
  logic [31:0] reg_wdata, reg_rdata, rv, ex;
  logic [NCH-1:0] read_done, write_done, read_last, write_last, read_permit, channel_active;
  logic [NEVT:1] sync_event;
  logic [NCH-1:0][31:0] read_addr, write_addr;
  logic [NCH-1:0][3:0] read_lanes, write_lanes;
  int err_total = 0;
  int samples_checked = 0;
  int cyc = 0;
  dma_addr_gen #(.NCH(NCH), .NEVT(NEVT)) dma_addr_gen_i (.clk(clk), .rst_n(rst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .read_done(read_done), .write_done(write_done),
    .sync_event(sync_event), .read_addr(read_addr), .write_addr(write_addr),
    .read_lanes(read_lanes), .write_lanes(write_lanes), .read_last(read_last),
    .write_last(write_last), .read_permit(read_permit), .channel_active(channel_active));
  // ----------------------------------------
  // Clock, timeout, report
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", err_total, samples_checked);
    if (err_total == 0 && samples_checked > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : complete_run
  // Ceiling is about twenty times the two hundred or so cycles the sequence needs
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      err_total = err_total + 1;
      complete_run();
    end
  end
  // ----------------------------------------
  // Bus and transfer tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      err_total++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'b0;
    @(negedge clk);
    d = reg_rdata;
  endtask : rd
  // Reads wait for permit, so the one-read-per-two-cycles spacing holds
  task automatic rdone(input int c);
    int n;
    n = 0;
    @(negedge clk);
    while (read_permit[c] !== 1'b1 && n < 50) begin
      @(negedge clk);
      n++;
    end
    if (n >= 50) begin
      chk(32'h0, 32'h1);
    end
    @(posedge clk);
    read_done[c] <= 1'b1;
    @(posedge clk);
    read_done[c] <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : rdone
  task automatic wdone(input int c);
    @(posedge clk);
    write_done[c] <= 1'b1;
    @(posedge clk);
    write_done[c] <= 1'b0;
    @(posedge clk);
    @(negedge clk);
  endtask : wdone
  task automatic start(input int c, input logic [31:0] ctl, input logic [31:0] s,
      input logic [31:0] d, input logic [31:0] cnt, input logic [31:0] rel);
    logic [7:0] b;
    b = 8'(c) * dma_addr_pkg::CH_STRIDE;
    wr(b + dma_addr_pkg::OFS_SRC, s);
    wr(b + dma_addr_pkg::OFS_DST, d);
    wr(b + dma_addr_pkg::OFS_CNT, cnt);
    wr(b + dma_addr_pkg::OFS_RELOAD, rel);
    wr(b + dma_addr_pkg::OFS_CTRL, ctl | 32'h0000_2000);
    repeat (2) @(negedge clk);
  endtask : start
  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    rst_n = 1'b0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 32'h0;
    read_done = '0;
    write_done = '0;
    sync_event = '0;
    repeat (4) @(posedge clk);
    rst_n <= 1'b1;
    rd(dma_addr_pkg::OFS_CTRL, rv);
    chk(rv, dma_addr_pkg::CTRL_RESET);
    rd(dma_addr_pkg::OFS_STEP0, rv);
    chk(rv, dma_addr_pkg::STEP_RESET);
    rd(8'h14, rv);
    chk(rv, 32'h0);
    // A done pulse on an idle channel must be ignored
    @(posedge clk);
    read_done[0] <= 1'b1;
    @(posedge clk);
    read_done[0] <= 1'b0;
    repeat (2) @(negedge clk);
    chk(read_addr[0], 32'h0);
    // Step register 0 differs so a wrong selection shows
    wr(dma_addr_pkg::OFS_STEP0, 32'h0000_0002);
    wr(dma_addr_pkg::OFS_STEP1, 32'hfff0_0006);
    // Halfword, source increments, destination decrements
    start(0, 32'h0000_0019, 32'h100, 32'h200, 32'h0001_0004, 32'h4);
    chk({28'h0, read_lanes[0]}, 32'h3);
    rdone(0);
    chk(read_addr[0], 32'h102);
    rdone(0);
    chk(read_addr[0], 32'h104);
    wdone(0);
    chk(write_addr[0], 32'h1fe);
    rd(dma_addr_pkg::OFS_SRC, rv);
    chk(rv, 32'h104);
    // Word decrement from zero wraps; destination held
    start(1, 32'h0000_0022, 32'h0, 32'h40, 32'h0001_0004, 32'h4);
    rdone(1);
    chk(read_addr[1], 32'hffff_fffc);
    wdone(1);
    chk(write_addr[1], 32'h40);
    chk(read_addr[0], 32'h104);
    // Byte increment in big-endian byte order
    wr(dma_addr_pkg::OFS_CFG, 32'h1);
    start(3, 32'h0000_0001, 32'h3, 32'h0, 32'h0001_0004, 32'h4);
    chk({28'h0, read_lanes[3]}, 32'h1);
    rdone(3);
    chk(read_addr[3], 32'h4);
    chk({28'h0, read_lanes[3]}, 32'h8);
    // Sorting walk: three frames of four halfwords with shared step register 1
    wr(dma_addr_pkg::OFS_CFG, 32'h0);
    start(2, 32'h0000_0053, 32'h8000_0000, 32'h0, 32'h0003_0004, 32'h4);
    ex = 32'h8000_0000;
    for (int f = 0; f < 3; f++) begin
      for (int e = 0; e < 4; e++) begin
        chk(read_addr[2], ex);
        chk({31'h0, read_last[2]}, {31'h0, e == 3});
        rdone(2);
        ex = (e == 3) ? ex - 32'd16 : ex + 32'd6;
      end
    end
    chk(read_addr[2], ex);
    // Finish channel 1, then a two-frame block: one word, then a reloaded frame of two
    repeat (3) rdone(1);
    repeat (3) wdone(1);
    chk({31'h0, channel_active[1]}, 32'h0);
    wr(dma_addr_pkg::OFS_STEP0, 32'h0004_0004);
    start(1, 32'h0000_0023, 32'h1000, 32'h0, 32'h0002_0001, 32'h2);
    chk({28'h0, write_lanes[1]}, 32'hf);
    chk({31'h0, write_last[1]}, 32'h1);
    for (int i = 0; i < 3; i++) begin
      chk(read_addr[1], 32'h1000 + 32'(4 * i));
      rdone(1);
    end
    chk(read_addr[1], 32'h100c);
    chk({31'h0, read_permit[1]}, 32'h0);
    // Frame sync: a single event on line 1 opens a whole two-word frame
    repeat (3) wdone(1);
    start(1, 32'h0000_01a1, 32'h2000, 32'h0, 32'h0001_0002, 32'h2);
    chk({31'h0, read_permit[1]}, 32'h0);
    @(posedge clk);
    sync_event[1] <= 1'b1;
    repeat (2) rdone(1);
    chk(read_addr[1], 32'h2008);
    complete_run();
  end
endmodule : tb
bind dma_addr_gen dma_addr_gen_chk #(.NCH(NCH), .NEVT(NEVT)) chk_i (.clk(clk), .rst_n(rst_n),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .read_done(read_done), .write_done(write_done),
  .sync_event(sync_event), .read_addr(read_addr), .write_addr(write_addr),
  .read_lanes(read_lanes), .write_lanes(write_lanes), .read_last(read_last),
  .write_last(write_last), .read_permit(read_permit), .channel_active(channel_active));
`default_nettype wire
